//--- core/fcd_commit.sv
// Purpose: decodes and executes the firmware commit command and posts its completion
// Assumes: classic Wishbone slave, 32-bit data, one clock, synchronous reset
// Notes:   slots are shared by all controllers of the subsystem; one activation output serves them all
//
// Behaviour
// (RQ1) parameters come only from command doubleword 10; other fields ignored
// (RQ2) bit 31 picks the boot partition, used only for partition actions
// (RQ3) action 000b stores image in slot without activation
// (RQ4) action 001b stores image and schedules it for next reset
// (RQ5) action 010b schedules existing slot image for next reset
// (RQ6) action 011b stores new image if any, activates slot immediately
// (RQ7) action 110b overwrites selected boot partition with downloaded image
// (RQ8) action 111b marks partition active and updates active partition id
// (RQ9) slot bits 02:00; zero means controller picks a slot 1 to 7
// (RQ10) slot commit checks a valid image was downloaded first
// (RQ11) slots and activated firmware are shared by every controller
// (RQ12) boot partition writes allowed only while unlocked
// (RQ13) one completion entry with status posted per command
// (RQ14) status 06h for invalid, read-only or unsupported slot
// (RQ15) status 1Eh for modifying a locked boot partition
// (RQ16) reserved actions 100b and 101b rejected, nothing changed
// (RQ17) bits 30 down to 6 are ignored in decoding
`timescale 1ns/1ps

`include "fcd_map.svh"

module fcd_commit
   import fcd_pkg::*;
#(
   parameter logic [2:0] NUM_SLOTS = `FCD_NUM_SLOTS,
   parameter int         REV_W     = `FCD_REV_W
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [3:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // download engine side, same clock
   input  wire logic              img_valid_i,
   input  wire logic [REV_W-1:0]  img_rev_i,
   input  wire logic              img_good_i,
   output logic                   img_consume_o,
   // partition store side
   output logic                   bp_write_o,
   output logic                   bp_write_sel_o,
   // subsystem-wide activation
   output logic                   act_now_o,
   output logic [2:0]             active_slot_o,
   output logic [2:0]             next_slot_o,
   output logic                   active_partition_id_o,
   // completion entry
   output logic                   cq_valid_o,
   output logic [7:0]             cq_status_o
);

   // -------------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------------
   fcd_state_t     state_ff;
   fcd_state_t     nxt_state;
   logic [31:0]    cmd_ff;
   logic           busy_ff;
   logic [1:0]     bp_lock_ff;
   logic [7:0]     ro_mask_ff;
   logic [7:0]     status_ff;
   logic           done_ff;
   logic [2:0]     slot_ff;
   logic [2:0]     next_slot_ff;
   logic           next_pend_ff;
   logic [2:0]     active_slot_ff;
   logic           abp_ff;
   logic           bp_write_ff;
   logic           bp_write_sel_ff;
   logic           act_now_ff;
   logic           consume_ff;
   logic           cq_valid_ff;
   logic [7:0]     cq_status_ff;
   logic           ack_ff;
   logic [31:0]    rdata_ff;
   logic [2:0]     rr_slot_ff;
   logic           mem_we;
   logic [REV_W-1:0] mem_rdata;
   logic           req;
   logic           wr_cmd;
   fcd_action_t    action;
   logic [2:0]     fs_field;
   logic           bps;
   logic [2:0]     eff_slot;
   logic [7:0]     nxt_status;

   // request qualifies once; ack drops the cycle after it was given
   assign req    = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_cmd = req & wb_we_i & (wb_adr_i == `FCD_OFS_CMD) & (&wb_sel_i) & ~busy_ff;

   // field decode of the captured doubleword; bits 30:6 never looked at
   assign action   = fcd_action_t'(cmd_ff[`FCD_CA_HI:`FCD_CA_LO]); // RQ3 RQ17
   assign fs_field = cmd_ff[`FCD_FS_HI:`FCD_FS_LO];                // RQ9 RQ17
   assign bps      = cmd_ff[`FCD_BPS_BIT];                         // RQ2

   // slot zero lets the controller choose: a held pick within 1..7 that steps on past a read-only slot
   assign eff_slot = (fs_field == 3'h0) ? rr_slot_ff : fs_field;   // RQ9

   // -------------------------------------------------------------------------
   // wishbone slave: single-cycle ack, registered read data
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= req;
         if (req & ~wb_we_i)
         begin
            case (wb_adr_i)
               `FCD_OFS_CMD:    rdata_ff <= cmd_ff;
               `FCD_OFS_CTRL:   rdata_ff <= {22'h0, bp_lock_ff, ro_mask_ff};
               `FCD_OFS_STATUS: rdata_ff <= {14'h0, active_slot_ff, next_pend_ff, next_slot_ff,
                                              abp_ff, busy_ff, done_ff, status_ff};
               `FCD_OFS_SLOTS:  rdata_ff <= {{(32-REV_W){1'b0}}, mem_rdata};
               default:         rdata_ff <= 32'h0000_0000;  // unmapped reads as zero
            endcase
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;

   // -------------------------------------------------------------------------
   // command capture; a write while busy is acked but dropped
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmd_ff <= 32'h0000_0000;
      end
      else if (wr_cmd)
      begin
         cmd_ff <= wb_dat_i;  // RQ1
      end
   end

   // -------------------------------------------------------------------------
   // control register: partition locks and read-only slot mask
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ro_mask_ff <= `FCD_RO_MASK_RST;
         bp_lock_ff <= 2'h0;
      end
      else if (req & wb_we_i & (wb_adr_i == `FCD_OFS_CTRL))
      begin
         if (wb_sel_i[0])
         begin
            ro_mask_ff <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1])
         begin
            bp_lock_ff <= wb_dat_i[9:8];
         end
      end
   end

   // -------------------------------------------------------------------------
   // executer state machine
   // -------------------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         FCD_IDLE:   nxt_state = wr_cmd ? FCD_DECODE : FCD_IDLE;
         FCD_DECODE: nxt_state = FCD_EXEC;
         FCD_EXEC:   nxt_state = FCD_POST;
         FCD_POST:   nxt_state = FCD_IDLE;
         default:    nxt_state = FCD_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= FCD_IDLE;
         busy_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         busy_ff  <= (nxt_state != FCD_IDLE);
      end
   end

   // -------------------------------------------------------------------------
   // status decision, first failing check wins
   // -------------------------------------------------------------------------
   always_comb
   begin
      nxt_status = `FCD_ST_OK;
      case (action)
         FCD_CA_STORE, FCD_CA_STORE_NEXT, FCD_CA_SCHED_NEXT, FCD_CA_ACT_NOW:
         begin
            if ((eff_slot > NUM_SLOTS) || (ro_mask_ff[eff_slot] &&
                (action != FCD_CA_SCHED_NEXT) && !(action == FCD_CA_ACT_NOW && !img_valid_i)))
            begin
               nxt_status = `FCD_ST_INV_SLOT;   // RQ14
            end
            else if ((action == FCD_CA_STORE || action == FCD_CA_STORE_NEXT) &&
                     !(img_valid_i && img_good_i))
            begin
               nxt_status = `FCD_ST_INV_IMAGE;  // RQ10
            end
            else if (action == FCD_CA_ACT_NOW && img_valid_i && !img_good_i)
            begin
               nxt_status = `FCD_ST_INV_IMAGE;  // RQ10
            end
         end
         FCD_CA_BP_WRITE:
         begin
            if (bp_lock_ff[bps])
            begin
               nxt_status = `FCD_ST_BP_LOCKED;  // RQ12 RQ15
            end
            else if (!(img_valid_i && img_good_i))
            begin
               nxt_status = `FCD_ST_INV_IMAGE;
            end
         end
         FCD_CA_BP_ACTIVE: nxt_status = `FCD_ST_OK;
         default:          nxt_status = `FCD_ST_INV_FIELD;  // RQ16
      endcase
   end

   // -------------------------------------------------------------------------
   // execution effects, taken only when the status is clean
   // -------------------------------------------------------------------------
   assign mem_we = (state_ff == FCD_EXEC) && (nxt_status == `FCD_ST_OK) &&
                   ((action == FCD_CA_STORE) || (action == FCD_CA_STORE_NEXT) ||
                    (action == FCD_CA_ACT_NOW && img_valid_i));  // RQ3 RQ4 RQ6

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         next_slot_ff    <= 3'h0;
         next_pend_ff    <= 1'b0;
         active_slot_ff  <= `FCD_ACTIVE_RST;
         abp_ff          <= 1'b0;
         bp_write_ff     <= 1'b0;
         bp_write_sel_ff <= 1'b0;
         act_now_ff      <= 1'b0;
         consume_ff      <= 1'b0;
         slot_ff         <= 3'h0;
      end
      else
      begin
         bp_write_ff <= 1'b0;
         act_now_ff  <= 1'b0;
         consume_ff  <= 1'b0;
         if (state_ff == FCD_EXEC && nxt_status == `FCD_ST_OK)
         begin
            slot_ff    <= eff_slot;
            consume_ff <= mem_we || (action == FCD_CA_BP_WRITE);
            case (action)
               FCD_CA_STORE_NEXT, FCD_CA_SCHED_NEXT:
               begin
                  next_slot_ff <= eff_slot;        // RQ4 RQ5
                  next_pend_ff <= 1'b1;
               end
               FCD_CA_ACT_NOW:
               begin
                  active_slot_ff <= eff_slot;      // RQ6 RQ11
                  act_now_ff     <= 1'b1;
                  next_pend_ff   <= 1'b0;
               end
               FCD_CA_BP_WRITE:
               begin
                  bp_write_ff     <= 1'b1;         // RQ7
                  bp_write_sel_ff <= bps;          // RQ2
               end
               FCD_CA_BP_ACTIVE:
               begin
                  abp_ff <= bps;                   // RQ8
               end
               default:
               begin
                  slot_ff <= slot_ff;
               end
            endcase
         end
      end
   end

   // held choice for slot zero, steps to the next slot only while it sits on a read-only one
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rr_slot_ff <= 3'h1;
      end
      else if (state_ff == FCD_DECODE && fs_field == 3'h0 && ro_mask_ff[rr_slot_ff])
      begin
         rr_slot_ff <= (rr_slot_ff >= NUM_SLOTS) ? 3'h1 : rr_slot_ff + 3'h1;
      end
   end

   // -------------------------------------------------------------------------
   // completion entry: exactly one pulse per accepted command
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cq_valid_ff  <= 1'b0;
         cq_status_ff <= 8'h00;
         status_ff    <= 8'h00;
         done_ff      <= 1'b0;
      end
      else
      begin
         cq_valid_ff <= 1'b0;
         if (wr_cmd)
         begin
            done_ff <= 1'b0;
         end
         if (state_ff == FCD_EXEC)
         begin
            cq_valid_ff  <= 1'b1;        // RQ13
            cq_status_ff <= nxt_status;  // RQ13
            status_ff    <= nxt_status;
            done_ff      <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // slot store; readback addressed by the slot field of the last command
   // -------------------------------------------------------------------------
   fcd_slot_mem #(
      .DW (REV_W),
      .AW (3)
   ) u_slots (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (mem_we),
      .waddr_i (eff_slot),
      .wdata_i (img_rev_i),
      .raddr_i (fs_field),
      .rdata_o (mem_rdata)
   );

   // outputs straight from flip-flops
   assign img_consume_o         = consume_ff;
   assign bp_write_o            = bp_write_ff;
   assign bp_write_sel_o        = bp_write_sel_ff;
   assign act_now_o             = act_now_ff;
   assign active_slot_o         = active_slot_ff;
   assign next_slot_o           = next_slot_ff;
   assign active_partition_id_o = abp_ff;
   assign cq_valid_o            = cq_valid_ff;
   assign cq_status_o           = cq_status_ff;

endmodule : fcd_commit

//--- core/fcd_map.svh
// Purpose: offsets, field positions, codes and reset values of the firmware commit decoder
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   definitions only
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define FCD_OFS_CMD        4'h0
`define FCD_OFS_CTRL       4'h4
`define FCD_OFS_STATUS     4'h8
`define FCD_OFS_SLOTS      4'hC

// ----------------------------------------------------------------------------
// command doubleword fields
// ----------------------------------------------------------------------------
`define FCD_BPS_BIT        31
`define FCD_CA_HI          5
`define FCD_CA_LO          3
`define FCD_FS_HI          2
`define FCD_FS_LO          0

// ----------------------------------------------------------------------------
// completion status codes
// ----------------------------------------------------------------------------
`define FCD_ST_OK          8'h00
`define FCD_ST_INV_FIELD   8'h02
`define FCD_ST_INV_SLOT    8'h06
`define FCD_ST_INV_IMAGE   8'h07
`define FCD_ST_BP_LOCKED   8'h1E

// ----------------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------------
`define FCD_NUM_SLOTS      3'h7
`define FCD_RO_MASK_RST    8'h02
`define FCD_ACTIVE_RST     3'h1
`define FCD_REV_W          8

`endif

//--- core/fcd_pkg.sv
// Purpose: types for the firmware commit decoder
// Assumes: nothing beyond the map header
// Notes:   one-hot state codes written out
package fcd_pkg;

   // commit action codes
   typedef enum logic [2:0] {
      FCD_CA_STORE      = 3'h0,
      FCD_CA_STORE_NEXT = 3'h1,
      FCD_CA_SCHED_NEXT = 3'h2,
      FCD_CA_ACT_NOW    = 3'h3,
      FCD_CA_RSVD4      = 3'h4,
      FCD_CA_RSVD5      = 3'h5,
      FCD_CA_BP_WRITE   = 3'h6,
      FCD_CA_BP_ACTIVE  = 3'h7
   } fcd_action_t;

   // executer states
   typedef enum logic [3:0] {
      FCD_IDLE   = 4'h1,
      FCD_DECODE = 4'h2,
      FCD_EXEC   = 4'h4,
      FCD_POST   = 4'h8
   } fcd_state_t;

endpackage : fcd_pkg

//--- core/fcd_slot_mem.sv
// Purpose: firmware slot store holding one revision word per slot
// Assumes: single clock, synchronous reset clears every slot
// Notes:   read data comes out of a register, one cycle after the address
`timescale 1ns/1ps

module fcd_slot_mem #(
   parameter int DW = 8,
   parameter int AW = 3
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);

   logic [DW-1:0] mem_ff [2**AW];

   // -------------------------------------------------------------------------
   // storage; reset clears so an empty slot reads as revision zero
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 2**AW; i++)
         begin
            mem_ff[i] <= '0;
         end
      end
      else if (we_i)
      begin
         mem_ff[waddr_i] <= wdata_i;
      end
   end

   // registered read port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= '0;
      end
      else
      begin
         rdata_o <= mem_ff[raddr_i];
      end
   end

endmodule : fcd_slot_mem

//--- verification/fcd_commit_asserts.sv
// Purpose: concurrent checks on the firmware commit decoder ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every fcd_commit instance
`timescale 1ns/1ps
`include "fcd_map.svh"

module fcd_commit_asserts #(
   parameter logic [2:0] NUM_SLOTS = `FCD_NUM_SLOTS
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       img_consume_o,
   input wire logic       bp_write_o,
   input wire logic       act_now_o,
   input wire logic [2:0] active_slot_o,
   input wire logic       active_partition_id_o,
   input wire logic       cq_valid_o,
   input wire logic [7:0] cq_status_o
);
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // a request sees ack on the very next edge, for one cycle only
   bus_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   // side effects only travel with their completion entry
   effect_with_cq_a: assert property ((act_now_o || bp_write_o || img_consume_o) |-> cq_valid_o)
      else $error("effect pulse without completion");
   cq_single_a: assert property (cq_valid_o |=> !cq_valid_o [*2])
      else $error("completions closer than the pipeline allows");
   status_hold_a: assert property (!cq_valid_o |-> $stable(cq_status_o))
      else $error("status moved between completions");
   act_ok_a: assert property (act_now_o |-> cq_status_o == `FCD_ST_OK)
      else $error("activation with failing status");
   slot_change_a: assert property ($changed(active_slot_o) |-> act_now_o)
      else $error("active slot moved without activation");
   slot_range_a: assert property (active_slot_o inside {[1:NUM_SLOTS]})
      else $error("active slot out of range");
   bp_write_ok_a: assert property (bp_write_o |-> img_consume_o && cq_status_o == `FCD_ST_OK)
      else $error("partition write without image use or with error");
   bp_locked_a: assert property ((cq_valid_o && cq_status_o == `FCD_ST_BP_LOCKED) |-> !bp_write_o && !img_consume_o)
      else $error("locked partition was written");
   part_id_a: assert property ($changed(active_partition_id_o) |-> cq_valid_o && !img_consume_o)
      else $error("partition id moved outside a mark-active completion");
   reject_clean_a: assert property ((cq_valid_o && cq_status_o inside {8'h02, 8'h06, 8'h07})
      |-> !(act_now_o || bp_write_o || img_consume_o))
      else $error("rejected command had an effect");
endmodule : fcd_commit_asserts

bind fcd_commit fcd_commit_asserts #(.NUM_SLOTS(NUM_SLOTS)) i_fcd_commit_asserts (.*);

//--- verification/fcd_img_src.sv
// Purpose: model of the download engine that offers an image to the decoder
// Assumes: same clock as the decoder
// Notes:   revision lines show inverted junk while no image is held
`timescale 1ns/1ps

module fcd_img_src (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       load_i,
   input  wire logic       drop_i,
   input  wire logic       good_i,
   input  wire logic [7:0] rev_i,
   input  wire logic       consume_i,
   output logic            valid_o,
   output logic            good_o,
   output logic      [7:0] rev_o
);
   logic       valid_ff;
   logic       good_ff;
   logic [7:0] rev_ff;

   // an image lives until the decoder uses it or the bench drops it
   always_ff @(posedge clk_i)
   begin
      if (rst_i || drop_i || consume_i)
         valid_ff <= 1'b0;
      else if (load_i)
         valid_ff <= 1'b1;
      if (load_i)
         rev_ff <= rev_i;
      if (load_i)
         good_ff <= good_i;
   end

   // stale revision is never shown as if it were still valid
   assign valid_o = valid_ff;
   assign good_o  = valid_ff & good_ff;
   assign rev_o   = valid_ff ? rev_ff : ~rev_ff;
endmodule : fcd_img_src

//--- verification/firmware_commit_decode_tb.sv
// Purpose: self-checking bench for the firmware commit decoder
// Assumes: 20 MHz clock, Wishbone master tasks, image source model
// Notes:   reserved command bits are filled with random junk
`timescale 1ns/1ps
`include "fcd_map.svh"

module firmware_commit_decode_tb;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ld, drp, gd, img_valid, img_good, consume;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, seed, q;
   logic [7:0] rev, img_rev, cq_status_o, last_rev;
   logic bp_write_o, bp_sel, act_now_o, part_id, cq_valid_o, g_act, g_bp, g_cons;
   logic [2:0] active_slot_o, next_slot_o, fsel;
   logic [1:0] locks;
   int failures, check_count;

   fcd_commit i_fcd_commit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .img_valid_i(img_valid), .img_rev_i(img_rev), .img_good_i(img_good),
      .img_consume_o(consume), .bp_write_o(bp_write_o), .bp_write_sel_o(bp_sel), .act_now_o(act_now_o),
      .active_slot_o(active_slot_o), .next_slot_o(next_slot_o), .active_partition_id_o(part_id),
      .cq_valid_o(cq_valid_o), .cq_status_o(cq_status_o));
   fcd_img_src i_fcd_img_src (.clk_i(clk_i), .rst_i(rst_i), .load_i(ld), .drop_i(drp), .good_i(gd),
      .rev_i(rev), .consume_i(consume), .valid_o(img_valid), .good_o(img_good), .rev_o(img_rev));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // expected status; img 0 none, 1 good, 2 bad
   function automatic logic [7:0] exp_st(logic [2:0] ca, logic [2:0] fs, logic bp, int img);
      if (ca == 3'h4 || ca == 3'h5) return `FCD_ST_INV_FIELD;
      if (ca == 3'h6) return locks[bp] ? `FCD_ST_BP_LOCKED : (img == 1 ? `FCD_ST_OK : `FCD_ST_INV_IMAGE);
      if (ca == 3'h7 || ca == 3'h2 || (ca == 3'h3 && img == 0)) return `FCD_ST_OK;
      if (fs == 3'h1) return `FCD_ST_INV_SLOT;
      return img == 1 ? `FCD_ST_OK : `FCD_ST_INV_IMAGE;
   endfunction : exp_st

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
      if (n >= 50) failures++;
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb

   // offer an image, issue a command, collect its completion
   task automatic run(input logic [2:0] ca, input logic [2:0] fs, input logic bp, input int img);
      int n;
      n = 0;
      @(posedge clk_i);
      rev <= 8'(rnd());
      {ld, drp, gd} <= {img != 0, img == 0, img == 1};
      @(posedge clk_i);
      last_rev = rev;
      {ld, drp} <= 2'b00;
      wb(1'b1, `FCD_OFS_CMD, (rnd() & 32'h7FFFFFC0) | {bp, 25'h0, ca, fs});
      do @(posedge clk_i); while (cq_valid_o !== 1'b1 && ++n < 20);
      {g_act, g_bp, g_cons} = {act_now_o, bp_write_o, consume};
      check(cq_valid_o, 1'b1);
      check(cq_status_o, exp_st(ca, fs, bp, img));
   endtask : run

   // ------------------------------------------------------------------
   // clock, watchdog, sequence
   // ------------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // the sequence needs a few hundred cycles at most
   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures++;
      test_done();
   end

   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ld, drp, gd} = 7'h41;
      {wb_adr_i, wb_sel_i, wb_dat_i, rev, locks, failures, check_count} = {4'h0, 4'hF, 32'h0, 8'h0, 2'h0, 64'h0};
      seed = 32'h0F53A927;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `FCD_OFS_CTRL, 32'h0); check(q, 32'h00000002);
      wb(1'b0, `FCD_OFS_STATUS, 32'h0); check(q[17:15], 3'h1);
      wb(1'b0, 4'h2, 32'h0); check(q, 32'h0);
      for (int k = 4; k < 6; k++)
      begin
         run(k[2:0], 3'h3, 1'b0, 1); check(g_cons, 1'b0);
      end
      run(3'h0, 3'h1, 1'b0, 1);
      run(3'h0, 3'h3, 1'b0, 2);
      run(3'h0, 3'h3, 1'b0, 0);
      run(3'h0, 3'h3, 1'b0, 1); check({g_cons, g_act}, 2'b10);
      wb(1'b0, `FCD_OFS_SLOTS, 32'h0); check(q[7:0], last_rev);
      run(3'h1, 3'h4, 1'b0, 1); check({g_cons, next_slot_o}, 4'hC);
      for (int k = 0; k < 4; k++)
      begin
         fsel = 3'h2 + 3'(rnd() % 6);
         run(3'h2, fsel, 1'b0, 0);
         check({g_cons, next_slot_o}, {1'b0, fsel});
      end
      run(3'h3, 3'h2, 1'b0, 1); check({g_act, g_cons, active_slot_o}, 5'h1A);
      run(3'h3, 3'h3, 1'b0, 0); check({g_act, g_cons, active_slot_o}, 5'h13);
      run(3'h3, 3'h0, 1'b0, 0); check(active_slot_o, 3'h2);
      locks = 2'b10;
      wb(1'b1, `FCD_OFS_CTRL, 32'h00000202);
      run(3'h6, 3'h0, 1'b1, 1); check(g_bp, 1'b0);
      run(3'h6, 3'h5, 1'b0, 1); check({g_bp, bp_sel}, 2'b10);
      run(3'h7, 3'h0, 1'b1, 0); check(part_id, 1'b1);
      run(3'h7, 3'h0, 1'b0, 0); check(part_id, 1'b0);
      test_done();
   end
endmodule : firmware_commit_decode_tb
